// *** hw/rrr_exec_pkg.sv ***
package rrr_exec_pkg;
  // widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PC_W = 15;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned STACK_DEPTH = 16;
  localparam int unsigned SP_W = 4;

  // bit positions
  localparam int unsigned IRQ_EN_BIT = 7; // global_irq_enable in irq_control_reg
  localparam int unsigned MSB_BIT = 7;

  // destination select encodings
  localparam logic DEST_W = 1'b0;
  localparam logic DEST_F = 1'b1;

  // cycle counts
  localparam logic [1:0] RET_CYCLES = 2'h2;
  localparam logic [1:0] ROT_CYCLES = 2'h1;

  // reset values
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;
  localparam logic [SP_W-1:0] SP_RST = 4'hf;
  localparam logic [DATA_W-1:0] W_RST = 8'h00;

  // operations offered by the decoder
  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_SOFT_RESET = 5'h01,
    OP_RETURN_FROM_IRQ = 5'h02,
    OP_RETURN = 5'h04,
    OP_RETURN_WITH_LITERAL = 5'h08,
    OP_ROTATE_LEFT_CARRY = 5'h10
  } op_type;

  // execution state, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RET2 = 3'b010,
    ST_RESET = 3'b100
  } state_type;
endpackage

// *** hw/return_stack.sv ***
`timescale 1ns/1ps
module return_stack
  import rrr_exec_pkg::*;
#(
  parameter int unsigned DEPTH = STACK_DEPTH,
  parameter int unsigned AW = SP_W,
  parameter int unsigned WIDTH = PC_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // push side, driven by call logic outside
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  // pop side
  input wire logic pop,
  // registered top entry and pointer
  output logic [WIDTH-1:0] top_of_stack,
  output logic [AW-1:0] stack_ptr
);
  // ----------------------------------------
  // storage and pointer
  // ----------------------------------------
  typedef struct packed {
    logic [AW-1:0] sp;
    logic [WIDTH-1:0] top;
  } stk_state_type;

  logic [WIDTH-1:0] mem [DEPTH];
  stk_state_type st_ff, nxt_st;
  logic [AW-1:0] up_ptr;
  logic [AW-1:0] dn_ptr;

  assign up_ptr = st_ff.sp + AW'(1);
  assign dn_ptr = st_ff.sp - AW'(1);

  // pop wins over push; the core never asks for both at once
  always_comb begin
    nxt_st = st_ff;
    if (pop) begin
      nxt_st.sp = dn_ptr;
      nxt_st.top = mem[dn_ptr];
    end else if (push) begin
      nxt_st.sp = up_ptr;
      nxt_st.top = push_data;
    end
  end

  // memory array holds no reset, only the pointer and the top register do
  always_ff @(posedge sys_clk) begin
    if (push && !pop) begin
      mem[up_ptr] <= push_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{sp: SP_RST, top: PC_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign top_of_stack = st_ff.top;
  assign stack_ptr = st_ff.sp;
endmodule

// *** hw/return_rotate_reset_exec.sv ***
`timescale 1ns/1ps
module return_rotate_reset_exec
  import rrr_exec_pkg::*;
#(
  parameter int unsigned DW = DATA_W,
  parameter int unsigned PW = PC_W,
  parameter int unsigned FW = FADDR_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // decoded instruction
  input wire logic op_valid,
  input wire op_type op_code,
  input wire logic [DW-1:0] literal,
  input wire logic [FW-1:0] file_addr,
  input wire logic dest_sel,
  // file register read data, addressed by file_addr
  input wire logic [DW-1:0] file_rdata,
  // call side pushes into the stack
  input wire logic stack_push,
  input wire logic [PW-1:0] stack_push_data,
  // incoming interrupt control and power-on style sets of the flag
  input wire logic [DW-1:0] irq_control_in,
  input wire logic irq_control_load,
  input wire logic soft_reset_flag_set,
  // execution status
  output logic busy,
  output logic device_reset_req,
  // program counter and stack
  output logic [PW-1:0] pc,
  output logic pc_load,
  output logic [SP_W-1:0] stack_ptr,
  // accumulator and status
  output logic [DW-1:0] accumulator,
  output logic carry,
  // file register write port
  output logic file_we,
  output logic [FW-1:0] file_waddr,
  output logic [DW-1:0] file_wdata,
  // control flags
  output logic [DW-1:0] irq_control_reg,
  output logic global_irq_enable,
  output logic soft_reset_flag_low
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    state_type fsm;
    logic [PW-1:0] pc;
    logic pc_load;
    logic [DW-1:0] w;
    logic c;
    logic fwe;
    logic [FW-1:0] fwa;
    logic [DW-1:0] fwd;
    logic [DW-1:0] irq_ctl;
    logic flag_n;
    logic rst_req;
    logic [PW-1:0] ret_addr;
  } exec_state_type;

  exec_state_type st_ff, nxt_st;
  logic pop;
  logic is_return;
  logic [PW-1:0] stk_top;
  logic [DW-1:0] rot_val;
  logic take;

  // ----------------------------------------
  // stack
  // ----------------------------------------
  return_stack #(
    .DEPTH(STACK_DEPTH),
    .AW(SP_W),
    .WIDTH(PW)
  ) u_stack (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .push(stack_push),
    .push_data(stack_push_data),
    .pop(pop),
    .top_of_stack(stk_top),
    .stack_ptr(stack_ptr)
  );

  // ----------------------------------------
  // instruction accept and return decode
  // ----------------------------------------
  // new instructions are only taken in idle, so busy stalls the decoder;
  // an op offered while busy is simply dropped, the decoder must hold it
  assign take = op_valid && (st_ff.fsm == ST_IDLE);

  // the three returns share one pop; every other op leaves the stack alone
  always_comb begin
    case (op_code)
      OP_RETURN_FROM_IRQ: is_return = 1'b1;
      OP_RETURN: is_return = 1'b1;
      OP_RETURN_WITH_LITERAL: is_return = 1'b1;
      default: is_return = 1'b0;
    endcase
  end

  // pop in the accept cycle so the pointer has moved by the second cycle
  assign pop = take && is_return;
  // old carry into bit zero, old msb out to carry
  assign rot_val = {file_rdata[DW-2:0], st_ff.c};

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.fwe = 1'b0;
    nxt_st.pc_load = 1'b0;
    nxt_st.rst_req = 1'b0;
    if (irq_control_load) begin
      nxt_st.irq_ctl = irq_control_in;
    end
    // a power-on style set from outside; the instruction's clear wins below
    if (soft_reset_flag_set) begin
      nxt_st.flag_n = 1'b1;
    end
    // the stack register moves to the older entry on the pop edge, so the
    // address being popped is caught here while it is still on top
    if (pop) begin
      nxt_st.ret_addr = stk_top;
    end
    case (st_ff.fsm)
      ST_IDLE: begin
        if (take) begin
          case (op_code)
            OP_SOFT_RESET: begin
              nxt_st.flag_n = 1'b0;
              nxt_st.rst_req = 1'b1;
              nxt_st.fsm = ST_RESET;
            end
            OP_RETURN_FROM_IRQ: begin
              nxt_st.irq_ctl[IRQ_EN_BIT] = 1'b1;
              nxt_st.fsm = ST_RET2;
            end
            OP_RETURN: begin
              nxt_st.fsm = ST_RET2;
            end
            OP_RETURN_WITH_LITERAL: begin
              nxt_st.w = literal;
              nxt_st.fsm = ST_RET2;
            end
            // rotate touches carry only; zero and digit carry stay untouched
            OP_ROTATE_LEFT_CARRY: begin
              nxt_st.c = file_rdata[MSB_BIT];
              if (dest_sel == DEST_W) begin
                nxt_st.w = rot_val;
              end else begin
                nxt_st.fwe = 1'b1;
                nxt_st.fwa = file_addr;
                nxt_st.fwd = rot_val;
              end
            end
            default: begin
              nxt_st.fsm = ST_IDLE;
            end
          endcase
        end
      end
      // second cycle: the address caught at the pop goes out with its strobe
      ST_RET2: begin
        nxt_st.pc = st_ff.ret_addr;
        nxt_st.pc_load = 1'b1;
        nxt_st.fsm = ST_IDLE;
      end
      // hold the request; the system reset pulls rst_n and ends this state
      ST_RESET: begin
        nxt_st.rst_req = 1'b1;
        nxt_st.flag_n = 1'b0;
      end
      default: begin
        nxt_st.fsm = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // the flag comes up set: only the instruction clears it, and a device
      // reset that must keep the cleared flag needs outside logic to hold it
      st_ff <= '{fsm: ST_IDLE, pc: PC_RST, pc_load: 1'b0, w: W_RST, c: 1'b0,
        fwe: 1'b0, fwa: '0, fwd: '0, irq_ctl: '0, flag_n: 1'b1, rst_req: 1'b0,
        ret_addr: PC_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // busy straight from the state register, so the decoder sees it early
  assign busy = (st_ff.fsm != ST_IDLE);
  assign device_reset_req = st_ff.rst_req;
  assign pc = st_ff.pc;
  assign pc_load = st_ff.pc_load;
  assign accumulator = st_ff.w;
  assign carry = st_ff.c;
  assign file_we = st_ff.fwe;
  assign file_waddr = st_ff.fwa;
  assign file_wdata = st_ff.fwd;
  assign irq_control_reg = st_ff.irq_ctl;
  assign global_irq_enable = st_ff.irq_ctl[IRQ_EN_BIT];
  assign soft_reset_flag_low = st_ff.flag_n;
endmodule

// *** test/rrr_exec_assertions.sv ***
`timescale 1ns/1ps
module rrr_exec_chk
  import rrr_exec_pkg::*;
(
  // watched ports
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic op_valid,
  input wire op_type op_code,
  input wire logic [DATA_W-1:0] literal,
  input wire logic [FADDR_W-1:0] file_addr,
  input wire logic dest_sel,
  input wire logic [DATA_W-1:0] file_rdata,
  input wire logic busy,
  input wire logic device_reset_req,
  input wire logic pc_load,
  input wire logic [SP_W-1:0] stack_ptr,
  input wire logic [DATA_W-1:0] accumulator,
  input wire logic carry,
  input wire logic file_we,
  input wire logic [FADDR_W-1:0] file_waddr,
  input wire logic [DATA_W-1:0] file_wdata,
  input wire logic [DATA_W-1:0] irq_control_reg,
  input wire logic global_irq_enable,
  input wire logic soft_reset_flag_low
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // accepted op and its kind; rotate result built from current carry
  logic take, is_ret, is_rot;
  logic [DATA_W-1:0] rot_res;
  assign take = op_valid && !busy;
  assign is_ret = op_code inside {OP_RETURN_FROM_IRQ, OP_RETURN, OP_RETURN_WITH_LITERAL};
  assign is_rot = take && op_code == OP_ROTATE_LEFT_CARRY;
  assign rot_res = {file_rdata[6:0], carry};
  // ----
  // properties
  // ----
  sequence s_ret_tail;
    busy ##1 (pc_load && !busy);
  endsequence
  property p_soft_reset;
    take && op_code == OP_SOFT_RESET |=> device_reset_req && !soft_reset_flag_low && busy;
  endproperty
  property p_ret_time;
    take && is_ret |=> s_ret_tail;
  endproperty
  property p_ret_pop;
    take && is_ret |=> stack_ptr == $past(stack_ptr) - 1'b1;
  endproperty
  property p_ret_flags;
    take && is_ret |=> $stable(carry);
  endproperty
  property p_irq_en;
    take && op_code == OP_RETURN_FROM_IRQ |=> global_irq_enable && irq_control_reg[IRQ_EN_BIT];
  endproperty
  property p_literal;
    take && op_code == OP_RETURN_WITH_LITERAL |=> accumulator == $past(literal);
  endproperty
  property p_rot_carry;
    is_rot |=> carry == $past(file_rdata[MSB_BIT]) && !busy;
  endproperty
  property p_rot_file;
    is_rot && dest_sel == DEST_F |=> file_we && file_wdata == $past(rot_res)
      && file_waddr == $past(file_addr);
  endproperty
  property p_rot_acc;
    is_rot && dest_sel == DEST_W |=> !file_we && accumulator == $past(rot_res);
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset not flagged");
  a_ret_time: assert property (p_ret_time)
    else $error("return not two cycles");
  a_ret_pop: assert property (p_ret_pop)
    else $error("stack pointer not stepped back");
  a_ret_flags: assert property (p_ret_flags)
    else $error("carry changed by return");
  a_irq_en: assert property (p_irq_en)
    else $error("global enable not set");
  a_literal: assert property (p_literal)
    else $error("literal not in accumulator");
  a_rot_carry: assert property (p_rot_carry)
    else $error("rotate carry wrong");
  a_rot_file: assert property (p_rot_file)
    else $error("rotate file write wrong");
  a_rot_acc: assert property (p_rot_acc)
    else $error("rotate accumulator wrong");
endmodule

bind return_rotate_reset_exec rrr_exec_chk i_chk (.sys_clk, .rst_n, .op_valid, .op_code,
  .literal, .file_addr, .dest_sel, .file_rdata, .busy, .device_reset_req, .pc_load,
  .stack_ptr, .accumulator, .carry, .file_we, .file_waddr, .file_wdata, .irq_control_reg,
  .global_irq_enable, .soft_reset_flag_low);

// *** test/test_return_rotate_reset_exec.sv ***
`timescale 1ns/1ps
module test_return_rotate_reset_exec
  import rrr_exec_pkg::*;
;
  logic sys_clk = 0, rst_n = 0, op_valid = 0, dest_sel = 0, stack_push = 0;
  logic irq_control_load = 0, flag_set = 0;
  op_type op_code = OP_NONE;
  op_type o;
  logic [7:0] literal = 0, file_rdata = 0, irq_control_in = 0;
  logic [6:0] file_addr = 0;
  logic [14:0] stack_push_data = 0, pc;
  logic busy, device_reset_req, pc_load, carry, file_we, global_irq_enable;
  logic soft_reset_flag_low;
  logic [3:0] stack_ptr, sp_e;
  logic [7:0] accumulator, file_wdata, irq_control_reg, res;
  logic [6:0] file_waddr;
  logic [14:0] q[$];
  logic [31:0] r;
  logic c_e;
  int error_cnt = 0, check_count = 0;
  integer seed = 32'hcce84932;
  // flag set pulsed while the soft reset holds: the instruction clear must win
  return_rotate_reset_exec i_return_rotate_reset_exec (.sys_clk, .rst_n, .op_valid, .op_code,
    .literal, .file_addr, .dest_sel, .file_rdata, .stack_push, .stack_push_data,
    .irq_control_in, .irq_control_load, .soft_reset_flag_set(flag_set), .busy, .device_reset_req,
    .pc, .pc_load, .stack_ptr, .accumulator, .carry, .file_we, .file_waddr, .file_wdata,
    .irq_control_reg, .global_irq_enable, .soft_reset_flag_low);
  initial forever #2.5 sys_clk = ~sys_clk;
  // ----
  // helpers
  // ----
  function automatic logic [7:0] rot(input logic [7:0] d, input logic c);
    return {d[6:0], c};
  endfunction
  task chk(input logic [16:0] got, input logic [16:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one op, then settle just past the answer edge
  task issue(input op_type t, input logic [31:0] v);
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_code <= t;
    literal <= v[7:0];
    file_rdata <= v[15:8];
    file_addr <= v[22:16];
    dest_sel <= v[23];
    @(posedge sys_clk);
    op_valid <= 1'b0;
    #1;
  endtask
  task push(input logic [14:0] v);
    @(posedge sys_clk);
    stack_push <= 1'b1;
    stack_push_data <= v;
    @(posedge sys_clk);
    stack_push <= 1'b0;
    q.push_back(v);
    sp_e++;
  endtask
  // random mix of pushes, rotates and the three returns
  initial begin
    sp_e = SP_RST;
    c_e = 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 300; i++) begin
      r = $random(seed);
      if (q.size() < 2 || (r[26:24] == 3'h0 && q.size() < 15)) push(r[14:0]);
      else if (r[25]) begin
        issue(OP_ROTATE_LEFT_CARRY, r);
        res = rot(r[15:8], c_e);
        c_e = r[15];
        chk({file_we, carry}, {r[23], c_e});
        if (r[23]) chk({file_waddr, file_wdata}, {r[22:16], res});
        else chk(accumulator, res);
      end else begin
        o = r[28] ? OP_RETURN_WITH_LITERAL : r[29] ? OP_RETURN_FROM_IRQ : OP_RETURN;
        if (o == OP_RETURN_FROM_IRQ) begin
          @(posedge sys_clk);
          irq_control_load <= 1'b1;
          irq_control_in <= {1'b0, r[6:0]};
          @(posedge sys_clk);
          irq_control_load <= 1'b0;
        end
        issue(o, r);
        sp_e--;
        chk({stack_ptr, busy, carry}, {sp_e, 1'b1, c_e});
        if (o == OP_RETURN_WITH_LITERAL) chk(accumulator, r[7:0]);
        if (o == OP_RETURN_FROM_IRQ)
          chk({global_irq_enable, irq_control_reg}, {2'b11, r[6:0]});
        @(posedge sys_clk);
        #1;
        chk({pc_load, busy, pc}, {2'b10, q.pop_back()});
      end
    end
    // software reset, then a rotate refused while it holds
    chk(soft_reset_flag_low, 1'b1);
    issue(OP_SOFT_RESET, r);
    chk({device_reset_req, soft_reset_flag_low, busy}, 3'b101);
    @(posedge sys_clk);
    flag_set <= 1'b1;
    issue(OP_ROTATE_LEFT_CARRY, 32'h0080ff00);
    chk({file_we, carry, device_reset_req, soft_reset_flag_low}, {1'b0, c_e, 2'b10});
    @(posedge sys_clk);
    rst_n <= 1'b0;
    flag_set <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    chk({device_reset_req, soft_reset_flag_low, stack_ptr}, {2'b01, SP_RST});
    report_and_stop();
  end
endmodule
